// *** inc/sram_wr_defines.svh ***
// Timing constants for the asynchronous SRAM write controller
`ifndef SRAM_WR_DEFINES_SVH
`define SRAM_WR_DEFINES_SVH
`define CLK_PERIOD_PS 10000
// Slowest grade figures in picoseconds
`define DATA_SETUP_PS 9000
`define ADDR_SETUP_PS 12000
`define WE_PULSE_OE_HIGH_PS 12000
`define WE_PULSE_OE_LOW_PS 17000
`define CYCLE_TIME_PS 20000
`define RELEASE_MAX_PS 9000
`define STROBE_HIGH_DRIVE_PS 3000
// Cycle counts, least times rounded up
`define CYC_UP(ps) (((ps) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define PULSE_OE_HIGH_CYC `CYC_UP(`WE_PULSE_OE_HIGH_PS)
`define PULSE_OE_LOW_CYC `CYC_UP(`WE_PULSE_OE_LOW_PS)
`define SETUP_CYC `CYC_UP(`DATA_SETUP_PS)
`define CYCLE_CYC `CYC_UP(`CYCLE_TIME_PS)
`define RELEASE_CYC `CYC_UP(`RELEASE_MAX_PS)
`define ADDR_SETUP_CYC `CYC_UP(`ADDR_SETUP_PS)
`endif

// *** inc/sram_wr_pkg.sv ***
// Types for the asynchronous SRAM write controller
package sram_wr_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SETUP = 3'b001,
      ST_STROBE = 3'b010,
      ST_RECOVER = 3'b011,
      ST_RETAIN = 3'b100,
      ST_WAKE = 3'b101
   } state_t;
endpackage

// *** design/sram_wr_ctrl.sv ***
// Host-side write and retention controller for an asynchronous SRAM
`timescale 1ns/100ps
`include "sram_wr_defines.svh"
module sram_wr_ctrl #(
   parameter int ADDR_W = 21,
   parameter int DATA_W = 8
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic wrReq,
   input wire logic [ADDR_W-1:0] wrAddr,
   input wire logic [DATA_W-1:0] wrData,
   input wire logic keepOeLow,
   input wire logic retainReq,
   output logic wrReady,
   output logic wrDone,
   output logic retainActive,
   output logic [ADDR_W-1:0] memAddr,
   output logic memSelN,
   output logic memStrobeN,
   output logic memOeN,
   output logic [DATA_W-1:0] dataLinesOut,
   output logic dataLinesOe,
   input wire logic [DATA_W-1:0] dataLinesIn
);
   import sram_wr_pkg::*;

   // Turnaround plus setup bounds the pulse when output enable stays low
   localparam int TURN_CYC = `RELEASE_CYC + `SETUP_CYC;
   localparam int LOW_CYC = (`PULSE_OE_LOW_CYC > TURN_CYC) ? `PULSE_OE_LOW_CYC : TURN_CYC;

   // Unsupported address or data widths, and counts that the 5-bit counter cannot serve, are refused
   if (ADDR_W < 1 || ADDR_W > 32) begin : g_bad_addr
      $error("sram_wr_ctrl: unsupported address width");
   end
   if (DATA_W < 1) begin : g_bad_data
      $error("sram_wr_ctrl: unsupported data width");
   end
   if (`PULSE_OE_HIGH_CYC < 1 || `PULSE_OE_HIGH_CYC > 31 || LOW_CYC > 31 || `SETUP_CYC < 1
         || `CYCLE_CYC < 1 || `CYCLE_CYC > 31) begin : g_bad_count
      $error("sram_wr_ctrl: timing count out of counter range");
   end
   // Select and data lead the strobe by one cycle
   if (`PULSE_OE_HIGH_CYC + 1 < `ADDR_SETUP_CYC || `PULSE_OE_HIGH_CYC + 1 < `SETUP_CYC) begin : g_bad_setup
      $error("sram_wr_ctrl: strobe pulse shorter than setup");
   end

   localparam logic [4:0] PULSE_HI = 5'(`PULSE_OE_HIGH_CYC);
   localparam logic [4:0] PULSE_LO = 5'(LOW_CYC);
   localparam logic [4:0] SETUP_N = 5'(`SETUP_CYC);
   localparam logic [4:0] CYCLE_N = 5'(`CYCLE_CYC);

   ////////////////////////////////////////////////////////////////////////
   state_t state_q, state_d;
   logic [4:0] count_q, count_d;
   logic [ADDR_W-1:0] addr_q;
   logic [DATA_W-1:0] data_q;
   logic oeLow_q;
   logic selN_q, strobeN_q, drive_q;
   logic doneP_q;

   wire idle = (state_q == ST_IDLE);
   wire startWrite = idle && wrReq && !retainReq;
   wire startRetain = idle && retainReq;
   wire countDone = (count_q == 5'h00);
   wire [4:0] pulseLen = oeLow_q ? PULSE_LO : PULSE_HI;
   wire strobeEnd = (state_q == ST_STROBE) && countDone;

   // Output enable low: memory drives until the strobe falls, so the host
   // holds off until the release time has passed
   wire oeLowNext = startWrite ? keepOeLow : oeLow_q;
   wire earlyDrive = (state_d == ST_SETUP || state_d == ST_STROBE) && !oeLowNext;
   wire lateDrive = (state_d == ST_STROBE) && (count_d < SETUP_N);
   wire driveNext = earlyDrive || lateDrive;

   // Next-state logic
   always_comb begin
      state_d = state_q;
      count_d = countDone ? 5'h00 : count_q - 5'h01;
      case (state_q)
         ST_IDLE: begin
            if (startRetain) begin
               state_d = ST_RETAIN;
            end else if (startWrite) begin
               state_d = ST_SETUP;
               count_d = 5'h00;
            end
         end
         ST_SETUP: begin
            state_d = ST_STROBE;
            count_d = pulseLen - 5'h01;
         end
         ST_STROBE: begin
            if (countDone) begin
               state_d = ST_RECOVER;
               count_d = 5'h00;
            end
         end
         ST_RECOVER: state_d = ST_IDLE;
         ST_RETAIN: begin
            if (!retainReq) begin
               state_d = ST_WAKE;
               count_d = CYCLE_N - 5'h01;
            end
         end
         ST_WAKE: begin
            if (countDone) begin
               state_d = ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock) begin
      if (reset) begin
         state_q <= ST_IDLE;
         count_q <= 5'h00;
      end else begin
         state_q <= state_d;
         count_q <= count_d;
      end
   end

   // Address and data latched at start, held through the whole pulse
   always_ff @(posedge clock) begin
      if (reset) begin
         addr_q <= '0;
         data_q <= '0;
         oeLow_q <= 1'b0;
      end else if (startWrite) begin
         addr_q <= wrAddr;
         data_q <= wrData;
         oeLow_q <= keepOeLow;
      end
   end

   // Select falls one cycle before strobe, strobe rise terminates the write
   always_ff @(posedge clock) begin
      if (reset) begin
         selN_q <= 1'b1;
         strobeN_q <= 1'b1;
         drive_q <= 1'b0;
         doneP_q <= 1'b0;
      end else begin
         selN_q <= !(state_d == ST_SETUP || state_d == ST_STROBE);
         strobeN_q <= !(state_d == ST_STROBE);
         drive_q <= driveNext;
         doneP_q <= strobeEnd;
      end
   end

   assign memAddr = addr_q;
   assign dataLinesOut = data_q;
   assign dataLinesOe = drive_q;
   assign memSelN = selN_q;
   assign memStrobeN = strobeN_q;
   assign memOeN = !(oeLow_q && !selN_q);
   assign wrReady = idle && !retainReq;
   assign wrDone = doneP_q;
   assign retainActive = (state_q == ST_RETAIN);

   ////////////////////////////////////////////////////////////////////////
   // Assertions on the pin sequence
   a_write_overlap: assert property (@(posedge clock) disable iff (reset)
      !memStrobeN |-> !memSelN && (dataLinesOe || !memOeN))
      else $error("strobe low without select or data");
   a_data_setup: assert property (@(posedge clock) disable iff (reset)
      $rose(memStrobeN) |-> $stable(dataLinesOut) [*1] ##0 $past(dataLinesOe))
      else $error("data not stable before write end");
   a_addr_stable: assert property (@(posedge clock) disable iff (reset)
      !memSelN && !$past(memSelN) |-> $stable(memAddr))
      else $error("address moved during write");
   a_pulse_len: assert property (@(posedge clock) disable iff (reset)
      $fell(memStrobeN) && !memOeN |-> !memStrobeN [*2])
      else $error("strobe pulse too short with output enable low");
   a_pulse_short: assert property (@(posedge clock) disable iff (reset)
      $fell(memStrobeN) && memOeN |-> !memStrobeN ##1 !memStrobeN)
      else $error("strobe pulse too short");
   a_retain_sel: assert property (@(posedge clock) disable iff (reset)
      retainActive |-> memSelN && memStrobeN)
      else $error("select active in retention");
   a_wake_wait: assert property (@(posedge clock) disable iff (reset)
      $fell(retainActive) |-> !wrReady ##1 !wrReady)
      else $error("access too soon after retention");
   a_done_pulse: assert property (@(posedge clock) disable iff (reset)
      $rose(memStrobeN) |-> wrDone ##1 !wrDone)
      else $error("done not aligned to write end");
   a_sel_setup: assert property (@(posedge clock) disable iff (reset)
      $fell(memSelN) |-> memStrobeN && (dataLinesOe == memOeN))
      else $error("controls not valid before strobe");
   a_no_clash: assert property (@(posedge clock) disable iff (reset)
      !memSelN && !memOeN && memStrobeN |-> !dataLinesOe)
      else $error("host drives while memory may drive");
   a_turn_wait: assert property (@(posedge clock) disable iff (reset)
      $fell(memStrobeN) && !memOeN |-> !dataLinesOe)
      else $error("host drives before memory released");
   a_addr_hold: assert property (@(posedge clock) disable iff (reset)
      $rose(memSelN) |-> $stable(memAddr))
      else $error("address moved at write end");
   a_drive_end: assert property (@(posedge clock) disable iff (reset)
      $rose(memStrobeN) |-> !dataLinesOe)
      else $error("data still driven after write end");
   a_write_gap: assert property (@(posedge clock) disable iff (reset)
      $rose(memStrobeN) |=> memStrobeN)
      else $error("strobe fell again right after write end");
endmodule

// *** verification/sram_model.sv ***
// Behavioural asynchronous SRAM facing the write controller
`timescale 1ns/100ps
module sram_model (
   input wire logic [20:0] addr,
   input wire logic selN,
   input wire logic strobeN,
   input wire logic oeN,
   input wire logic [7:0] pins,
   output logic [7:0] q,
   output logic drive
);
   logic [7:0] cells [int];
   logic ov = 1'b0;
   logic [7:0] late;
   // Pins seen a moment late: a release at the ending edge keeps zero hold
   assign #0.1 late = pins;
   wire en = !selN && !oeN && strobeN;
   initial drive = 1'b0;
   // Store on whichever control ends the overlap
   always @(selN or strobeN) begin
      if (!selN && !strobeN) begin
         ov = 1'b1;
      end else if (ov) begin
         cells[addr] = late;
         ov = 1'b0;
      end
   end
   always @(negedge en) drive = 1'b0;
   always @(posedge en) begin
      #3 drive = en;
      q = cells.exists(addr) ? cells[addr] : 8'h5a;
   end
endmodule

// *** verification/tb.sv ***
// Self-checking bench for the SRAM write controller
`timescale 1ns/100ps
module tb;
   logic clock = 1'b0, reset = 1'b1, wrReq = 1'b0, keepOeLow = 1'b0, retainReq = 1'b0;
   logic [20:0] wrAddr = 21'h0, memAddr;
   logic [7:0] wrData = 8'h0, dataLinesOut, q, pins;
   logic wrReady, wrDone, retainActive, memSelN, memStrobeN, memOeN, dataLinesOe, drive;
   logic lastOe = 1'b0;
   int errors = 0, samplesChecked = 0, cyc = 0;
   realtime tA = 0, tD = 0, tF = 0, tO = 0;
   always #5 clock = ~clock;
   assign pins = dataLinesOe ? dataLinesOut : (drive ? q : ~dataLinesOut);
   sram_wr_ctrl dut (.clock(clock), .reset(reset), .wrReq(wrReq), .wrAddr(wrAddr),
      .wrData(wrData), .keepOeLow(keepOeLow), .retainReq(retainReq), .wrReady(wrReady),
      .wrDone(wrDone), .retainActive(retainActive), .memAddr(memAddr), .memSelN(memSelN),
      .memStrobeN(memStrobeN), .memOeN(memOeN), .dataLinesOut(dataLinesOut),
      .dataLinesOe(dataLinesOe), .dataLinesIn(pins));
   sram_model mem (.addr(memAddr), .selN(memSelN), .strobeN(memStrobeN), .oeN(memOeN),
      .pins(pins), .q(q), .drive(drive));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(string n, logic [20:0] e, logic [20:0] g);
      samplesChecked++;
      if (g !== e) begin
         errors++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chkMin(string n, realtime lo, realtime g);
      samplesChecked++;
      if (g < lo) begin
         errors++;
         $display("wrong value %s expected >= %0.1f seen %0.1f", n, lo, g);
      end
   endtask
   task automatic tally_and_finish();
      $display("errors %0d samplesChecked %0d", errors, samplesChecked);
      if (errors == 0 && samplesChecked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Pin timing measured from the falling and the terminating strobe edges
   always @(memAddr) tA = $realtime;
   always @(dataLinesOut) tD = $realtime;
   always @(posedge dataLinesOe) begin
      tO = $realtime;
      if (lastOe) begin
         chkMin("turnaround", 9.0, tO - tF);
      end
   end
   always @(negedge memStrobeN) begin
      tF = $realtime;
      chk("select before strobe", 1'b0, memSelN);
   end
   always @(posedge memStrobeN) if (!reset) begin
      chkMin("data setup", 9.0, $realtime - tD);
      chkMin("drive setup", 9.0, $realtime - tO);
      chkMin("addr setup", 12.0, $realtime - tA);
      chkMin("strobe width", lastOe ? 17.0 : 12.0, $realtime - tF);
   end
   always @(posedge clock) begin
      cyc++;
      if (cyc > 2000) begin
         errors++;
         tally_and_finish();
      end
   end
   task automatic wr(logic [20:0] a, logic [7:0] d, logic o);
      @(posedge clock);
      wrReq <= 1'b1;
      wrAddr <= a;
      wrData <= d;
      keepOeLow <= o;
      lastOe = o;
      @(posedge clock);
      wrReq <= 1'b0;
      repeat (2) @(posedge clock);
      #1 chk("done early", 1'b0, wrDone);
      chk("output enable", !o, memOeN);
      @(posedge clock);
      #1 chk("done", 1'b1, wrDone);
      chk("stored", {13'h0, d}, {13'h0, mem.cells[a]});
      @(posedge clock);
      #1 chk("ready again", 1'b1, wrReady);
      chk("done one cycle", 1'b0, wrDone);
   endtask
   task automatic retainRefuse();
      @(posedge clock);
      retainReq <= 1'b1;
      wrReq <= 1'b1;
      wrAddr <= 21'h00077;
      repeat (3) @(posedge clock);
      #1 chk("retain", 1'b1, retainActive);
      chk("select parked", 1'b1, memSelN);
      @(posedge clock);
      retainReq <= 1'b0;
      wrReq <= 1'b0;
      repeat (2) @(posedge clock);
      #1 chk("wake wait", 1'b0, wrReady);
      @(posedge clock);
      #1 chk("awake", 1'b1, wrReady);
      chk("refused", 1'b0, mem.cells.exists(21'h00077));
   endtask
   initial begin
      repeat (4) @(posedge clock);
      reset <= 1'b0;
      #1 chk("reset select", 1'b1, memSelN);
      chk("reset strobe", 1'b1, memStrobeN);
      chk("reset drive", 1'b0, dataLinesOe);
      wr(21'h000000, 8'ha5, 1'b0);
      wr(21'h1fffff, 8'hff, 1'b1);
      wr(21'h0a5a5, 8'h3c, 1'b0);
      retainRefuse();
      wr(21'h000000, 8'h5e, 1'b1);
      tally_and_finish();
   end
endmodule
